/* src/adc_ctl_pkg.sv */
// Shared constants, register map and carrier types of the converter control block
package adc_ctl_pkg;

    // Clock and timing
    localparam int unsigned CLK_PERIOD_NS    = 10;
    localparam int unsigned CLK_HZ           = 100_000_000;
    localparam int unsigned RC_FREQ_HZ       = 600_000;
    // Longest time, so the divide rounds down
    localparam int unsigned RC_DIV           = CLK_HZ / RC_FREQ_HZ;
    // One instruction cycle is four system clock periods
    localparam int unsigned INSTR_CYCLE_NS   = 40;
    // Least time, so the count rounds up
    localparam int unsigned INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Result width
    localparam int unsigned RES_W = 10;

    // Bus geometry
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_TIMING_FORMAT = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CONV_CONTROL  = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_RESULT_HIGH   = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_RESULT_LOW    = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS    = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK      = 5'h14;

    // Field positions
    localparam int unsigned JUSTIFY_BIT  = 7;
    localparam int unsigned ACQ_SEL_LSB  = 3;
    localparam int unsigned CLK_SEL_LSB  = 0;
    localparam int unsigned START_BIT    = 0;
    localparam int unsigned DONE_BIT     = 0;

    // Reset values
    localparam logic [7:0] TIMING_FORMAT_RST = 8'h00;
    localparam logic [7:0] RESULT_RST        = 8'h00;

    // Conversion clock select codes that pick the internal RC clock
    localparam logic [2:0] CLK_SEL_RC_A = 3'h3;
    localparam logic [2:0] CLK_SEL_RC_B = 3'h7;

    // Acquisition delay, in converter clock periods
    function automatic logic [4:0] acq_periods(input logic [2:0] code);
        case (code)
            3'h0:    acq_periods = 5'h00;
            3'h1:    acq_periods = 5'h02;
            3'h2:    acq_periods = 5'h04;
            3'h3:    acq_periods = 5'h06;
            3'h4:    acq_periods = 5'h08;
            3'h5:    acq_periods = 5'h0c;
            3'h6:    acq_periods = 5'h10;
            default: acq_periods = 5'h14;
        endcase
    endfunction

    // System clock divide ratio for one converter clock period
    function automatic logic [7:0] clk_divide(input logic [2:0] code);
        case (code)
            3'h0:    clk_divide = 8'h02;
            3'h1:    clk_divide = 8'h08;
            3'h2:    clk_divide = 8'h20;
            3'h4:    clk_divide = 8'h04;
            3'h5:    clk_divide = 8'h10;
            3'h6:    clk_divide = 8'h40;
            default: clk_divide = RC_DIV[7:0];
        endcase
    endfunction

    // Avalon-MM request from the master
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
        logic [3:0]        byteenable;
    } avmm_req_t;

    // Avalon-MM answer to the master
    typedef struct packed {
        logic              waitrequest;
        logic [DATA_W-1:0] readdata;
    } avmm_rsp_t;

    // Sampling capacitor control towards the analogue front end
    typedef struct packed {
        logic connect;
        logic discharge;
    } cap_ctrl_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACQUIRE,
        ST_HOLDOFF,
        ST_CONVERT
    } conv_state_t;

endpackage

/* src/tad_tick_gen.sv */
// Converter clock period enable generator
`timescale 1ns/1ps
`default_nettype none
module tad_tick_gen (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    // Control
    input  wire logic       restart_i,
    input  wire logic [2:0] clk_sel_i,
    // Enable pulse
    output logic            tick_o
);

    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } tick_state_t;

    tick_state_t st;
    tick_state_t next_st;

    // Restart aligns the first period to the start request
    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        if (restart_i) begin
            next_st.cnt = 8'h00;
        end else if (st.cnt >= adc_ctl_pkg::clk_divide(clk_sel_i) - 8'h01) begin
            next_st.cnt  = 8'h00;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 8'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

endmodule
`default_nettype wire

/* src/sar_engine.sv */
// Successive approximation register, one result bit per converter clock period
`timescale 1ns/1ps
`default_nettype none
module sar_engine #(
    parameter int unsigned RES_W = 10
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    // Control
    input  wire logic             start_i,
    input  wire logic             step_i,
    input  wire logic             cmp_i,
    // Trial code and result
    output logic [RES_W-1:0]      trial_o,
    output logic                  done_o
);

    initial begin
        if (RES_W < 2 || RES_W > 16) begin
            $error("sar_engine: RES_W out of range");
        end
    end

    typedef struct packed {
        logic             active;
        logic [3:0]       idx;
        logic [RES_W-1:0] trial;
        logic             done;
    } sar_state_t;

    sar_state_t st;
    sar_state_t next_st;

    // Comparator high means the input is at or above the trial level: keep the bit
    always_comb begin
        next_st      = st;
        next_st.done = 1'b0;
        if (start_i) begin
            next_st.active = 1'b1;
            next_st.idx    = 4'(RES_W - 1);
            next_st.trial  = '0;
            next_st.trial[RES_W-1] = 1'b1;
        end else if (st.active && step_i) begin
            if (!cmp_i) begin
                next_st.trial[st.idx] = 1'b0;
            end
            if (st.idx == 4'h0) begin
                next_st.active = 1'b0;
                next_st.done   = 1'b1;
            end else begin
                next_st.idx = st.idx - 4'h1;
                next_st.trial[st.idx - 4'h1] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign trial_o = st.trial;
    assign done_o  = st.done;

endmodule
`default_nettype wire

/* src/adc_timing_format.sv */
// Converter timing, start sequencing and result formatting with an Avalon-MM register slave
//
// How it works
// - Format bit picks right or left justify
// - Acquisition field maps to 0..20 converter periods
// - Capacitor stays connected through acquisition delay
// - Clock field picks divider or RC clock
// - RC clock adds one instruction cycle holdoff
// - Left justify: bits 9..2 in high byte
// - Left justify: bits 1..0 in low 7..6
// - Right justify: bits 9..8 in high 1..0
// - Right justify: bits 7..0 in low byte
// - Timing register bit six reads zero
// - Capacitor discharged after every conversion
// - Start bit stays set until conversion completes
`timescale 1ns/1ps
`default_nettype none
module adc_timing_format #(
    parameter int unsigned HOLDOFF_CLKS = adc_ctl_pkg::INSTR_CYCLE_CLKS
) (
    // Clock and reset
    input  wire logic                                  mclk_i,
    input  wire logic                                  rst_n_i,
    // Register bus
    input  wire adc_ctl_pkg::avmm_req_t                avmm_req_i,
    output adc_ctl_pkg::avmm_rsp_t                     avmm_rsp_o,
    // Analogue front end
    input  wire logic                                  cmp_i,
    output logic [adc_ctl_pkg::RES_W-1:0]              dac_code_o,
    output adc_ctl_pkg::cap_ctrl_t                     cap_ctrl_o,
    // Interrupt
    output logic                                       irq_o
);

    localparam int unsigned RES_W = adc_ctl_pkg::RES_W;

    initial begin
        if (HOLDOFF_CLKS < 1 || HOLDOFF_CLKS > 255) begin
            $error("adc_timing_format: HOLDOFF_CLKS out of range");
        end
        // The divider counts in eight bits, and the comparator path needs five clocks a period
        if (adc_ctl_pkg::RC_DIV < 5 || adc_ctl_pkg::RC_DIV > 255) begin
            $error("adc_timing_format: RC_DIV out of range");
        end
    end

    // Whole state of the block
    typedef struct packed {
        adc_ctl_pkg::conv_state_t state;
        logic                     justify;
        logic [2:0]               acq_sel;
        logic [2:0]               clk_sel;
        logic [7:0]               res_high;
        logic [7:0]               res_low;
        logic                     done_sts;
        logic                     done_mask;
        logic                     irq;
        logic [4:0]               acq_left;
        logic [7:0]               hold_left;
        logic                     sar_start;
        logic                     connect;
        logic                     discharge;
        logic                     waitreq;
        logic [31:0]              rdata;
        logic [1:0]               cmp_sync;
    } ctl_state_t;

    ctl_state_t st;
    ctl_state_t next_st;

    logic             tad_tick;
    logic             tad_restart;
    logic             sar_done;
    logic [RES_W-1:0] sar_trial;

    // Converter clock period enable from the selected divider or the RC rate
    tad_tick_gen u_tad (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .restart_i (tad_restart),
        .clk_sel_i (st.clk_sel),
        .tick_o    (tad_tick)
    );

    // Bit decisions are made once per converter clock period
    sar_engine #(
        .RES_W (RES_W)
    ) u_sar (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .start_i (st.sar_start),
        .step_i  (tad_tick && st.state == adc_ctl_pkg::ST_CONVERT),
        .cmp_i   (st.cmp_sync[1]),
        .trial_o (sar_trial),
        .done_o  (sar_done)
    );

    // Bus decode helpers
    logic        bus_req;
    logic        bus_take;
    logic        bus_wr;
    logic        bus_rd;
    logic [7:0]  wbyte;
    logic        rc_sel;
    logic        start_req;
    logic [7:0]  fmt_high;
    logic [7:0]  fmt_low;

    assign bus_req  = avmm_req_i.read || avmm_req_i.write;
    assign bus_take = bus_req && !st.waitreq;
    assign bus_wr   = bus_take && avmm_req_i.write && avmm_req_i.byteenable[0];
    assign bus_rd   = bus_req && st.waitreq && avmm_req_i.read;
    assign wbyte    = avmm_req_i.writedata[7:0];
    assign rc_sel   = (st.clk_sel == adc_ctl_pkg::CLK_SEL_RC_A) || (st.clk_sel == adc_ctl_pkg::CLK_SEL_RC_B);
    assign start_req = bus_wr && avmm_req_i.address == adc_ctl_pkg::OFS_CONV_CONTROL
                       && wbyte[adc_ctl_pkg::START_BIT];
    // Restart the divider on the very edge the start is taken; a registered restart
    // would let one stale tick shorten the acquisition count by a whole period
    assign tad_restart = start_req && st.state == adc_ctl_pkg::ST_IDLE;

    // Result layout chosen by the format bit at completion
    always_comb begin
        if (st.justify) begin
            fmt_high = {6'h00, sar_trial[9:8]};
            fmt_low  = sar_trial[7:0];
        end else begin
            fmt_high = sar_trial[9:2];
            fmt_low  = {sar_trial[1:0], 6'h00};
        end
    end

    // Read data mux; reserved and unmapped bits read as zero
    logic [7:0] rd_byte;
    always_comb begin
        case (avmm_req_i.address)
            adc_ctl_pkg::OFS_TIMING_FORMAT: rd_byte = {st.justify, 1'b0, st.acq_sel, st.clk_sel};
            adc_ctl_pkg::OFS_CONV_CONTROL:  rd_byte = {7'h00, st.state != adc_ctl_pkg::ST_IDLE};
            adc_ctl_pkg::OFS_RESULT_HIGH:   rd_byte = st.res_high;
            adc_ctl_pkg::OFS_RESULT_LOW:    rd_byte = st.res_low;
            adc_ctl_pkg::OFS_IRQ_STATUS:    rd_byte = {7'h00, st.done_sts};
            adc_ctl_pkg::OFS_IRQ_MASK:      rd_byte = {7'h00, st.done_mask};
            default:                        rd_byte = 8'h00;
        endcase
    end

    // Next state of the whole block
    always_comb begin
        next_st              = st;
        next_st.sar_start    = 1'b0;
        next_st.discharge    = 1'b0;
        next_st.cmp_sync     = {st.cmp_sync[0], cmp_i};

        // Bus handshake: one wait cycle, then a one-cycle answer
        if (bus_req && st.waitreq) begin
            next_st.waitreq = 1'b0;
            next_st.rdata   = bus_rd ? {24'h000000, rd_byte} : 32'h00000000;
        end else begin
            next_st.waitreq = 1'b1;
        end

        // Software writes to configuration and result bytes
        if (bus_wr) begin
            case (avmm_req_i.address)
                adc_ctl_pkg::OFS_TIMING_FORMAT: begin
                    next_st.justify = wbyte[adc_ctl_pkg::JUSTIFY_BIT];
                    next_st.acq_sel = wbyte[adc_ctl_pkg::ACQ_SEL_LSB +: 3];
                    next_st.clk_sel = wbyte[adc_ctl_pkg::CLK_SEL_LSB +: 3];
                end
                adc_ctl_pkg::OFS_RESULT_HIGH: next_st.res_high = wbyte;
                adc_ctl_pkg::OFS_RESULT_LOW:  next_st.res_low  = wbyte;
                adc_ctl_pkg::OFS_IRQ_STATUS: begin
                    if (wbyte[adc_ctl_pkg::DONE_BIT]) begin
                        next_st.done_sts = 1'b0;
                    end
                end
                adc_ctl_pkg::OFS_IRQ_MASK: next_st.done_mask = wbyte[adc_ctl_pkg::DONE_BIT];
                default: ;
            endcase
        end

        // Conversion sequencer
        case (st.state)
            adc_ctl_pkg::ST_IDLE: begin
                // Start while idle only; a zero delay leaves the wait to software
                if (start_req) begin
                    next_st.connect      = 1'b1;
                    next_st.acq_left     = adc_ctl_pkg::acq_periods(st.acq_sel);
                    next_st.hold_left    = 8'(HOLDOFF_CLKS);
                    if (adc_ctl_pkg::acq_periods(st.acq_sel) != 5'h00) begin
                        next_st.state = adc_ctl_pkg::ST_ACQUIRE;
                    end else if (rc_sel) begin
                        next_st.state = adc_ctl_pkg::ST_HOLDOFF;
                    end else begin
                        next_st.state     = adc_ctl_pkg::ST_CONVERT;
                        next_st.connect   = 1'b0;
                        next_st.sar_start = 1'b1;
                    end
                end
            end
            adc_ctl_pkg::ST_ACQUIRE: begin
                // Capacitor tracks the channel until the last period ends
                if (tad_tick) begin
                    next_st.acq_left = st.acq_left - 5'h01;
                    if (st.acq_left == 5'h01) begin
                        if (rc_sel) begin
                            next_st.state = adc_ctl_pkg::ST_HOLDOFF;
                        end else begin
                            next_st.state     = adc_ctl_pkg::ST_CONVERT;
                            next_st.connect   = 1'b0;
                            next_st.sar_start = 1'b1;
                        end
                    end
                end
            end
            adc_ctl_pkg::ST_HOLDOFF: begin
                // Lets a sleep instruction execute before the quiet conversion
                next_st.hold_left = st.hold_left - 8'h01;
                if (st.hold_left == 8'h01) begin
                    next_st.state     = adc_ctl_pkg::ST_CONVERT;
                    next_st.connect   = 1'b0;
                    next_st.sar_start = 1'b1;
                end
            end
            adc_ctl_pkg::ST_CONVERT: begin
                // Hardware result write wins over a software write in the same cycle
                if (sar_done) begin
                    next_st.state     = adc_ctl_pkg::ST_IDLE;
                    next_st.res_high  = fmt_high;
                    next_st.res_low   = fmt_low;
                    next_st.discharge = 1'b1;
                    next_st.done_sts  = 1'b1;                 // Set wins over clear
                end
            end
            default: begin
                next_st.state = adc_ctl_pkg::ST_IDLE;
            end
        endcase

        next_st.irq = next_st.done_sts && next_st.done_mask;
    end

    // Single register stage for all state
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st          <= '0;
            st.state    <= adc_ctl_pkg::ST_IDLE;
            st.justify  <= adc_ctl_pkg::TIMING_FORMAT_RST[adc_ctl_pkg::JUSTIFY_BIT];
            st.acq_sel  <= adc_ctl_pkg::TIMING_FORMAT_RST[adc_ctl_pkg::ACQ_SEL_LSB +: 3];
            st.clk_sel  <= adc_ctl_pkg::TIMING_FORMAT_RST[adc_ctl_pkg::CLK_SEL_LSB +: 3];
            st.res_high <= adc_ctl_pkg::RESULT_RST;
            st.res_low  <= adc_ctl_pkg::RESULT_RST;
            st.waitreq  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flops
    assign avmm_rsp_o.waitrequest = st.waitreq;
    assign avmm_rsp_o.readdata    = st.rdata;
    assign cap_ctrl_o.connect     = st.connect;
    assign cap_ctrl_o.discharge   = st.discharge;
    assign dac_code_o             = sar_trial;
    assign irq_o                  = st.irq;

endmodule
`default_nettype wire

/* verif/adc_timing_format_assertions.sv */
// Concurrent checks on the ports of the converter timing and format block
`timescale 1ns/1ps
`default_nettype none
module adc_timing_format_assertions (
    // Clock and reset
    input wire logic                             mclk_i,
    input wire logic                             rst_n_i,
    // Watched ports
    input wire adc_ctl_pkg::avmm_req_t           avmm_req_i,
    input wire adc_ctl_pkg::avmm_rsp_t           avmm_rsp_o,
    input wire logic [adc_ctl_pkg::RES_W-1:0]    dac_code_o,
    input wire adc_ctl_pkg::cap_ctrl_t           cap_ctrl_o,
    input wire logic                             irq_o
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // A request is answered in the very next cycle
    property p_bus_answer;
        (avmm_req_i.read || avmm_req_i.write) && avmm_rsp_o.waitrequest |=> !avmm_rsp_o.waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");
    // The answer lasts a single cycle
    property p_bus_single;
        !avmm_rsp_o.waitrequest |=> avmm_rsp_o.waitrequest;
    endproperty
    a_bus_single: assert property (p_bus_single) else $error("bus answer too long");
    // Registers are eight bits wide, the rest reads zero
    property p_read_upper;
        !avmm_rsp_o.waitrequest |-> avmm_rsp_o.readdata[31:8] == 24'h000000;
    endproperty
    a_read_upper: assert property (p_read_upper) else $error("upper read data set");
    property p_bit6_zero;
        avmm_req_i.read && !avmm_rsp_o.waitrequest && avmm_req_i.address == 5'h00 |-> !avmm_rsp_o.readdata[6];
    endproperty
    a_bit6_zero: assert property (p_bit6_zero) else $error("timing bit six set");
    // Only a taken start write connects the capacitor
    property p_start_cause;
        $rose(cap_ctrl_o.connect) |-> $past(avmm_req_i.write && !avmm_rsp_o.waitrequest
            && avmm_req_i.address == 5'h04 && avmm_req_i.writedata[0]);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("connect without start");
    // The approximation opens at mid scale once sampling ends
    property p_sar_first;
        $fell(cap_ctrl_o.connect) |-> ##[0:2] dac_code_o == 10'h200;
    endproperty
    a_sar_first: assert property (p_sar_first) else $error("no mid scale trial");
    property p_discharge_pulse;
        cap_ctrl_o.discharge |=> !cap_ctrl_o.discharge;
    endproperty
    a_discharge_pulse: assert property (p_discharge_pulse) else $error("discharge too long");
    // Discharging while connected would short the input
    property p_discharge_open;
        cap_ctrl_o.discharge |-> !cap_ctrl_o.connect;
    endproperty
    a_discharge_open: assert property (p_discharge_open) else $error("discharge while connected");
    // The interrupt moves only after completion or a register write
    property p_irq_rise;
        $rose(irq_o) |-> cap_ctrl_o.discharge || $past(avmm_req_i.write && !avmm_rsp_o.waitrequest);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt without cause");
    property p_irq_fall;
        $fell(irq_o) |-> $past(avmm_req_i.write && !avmm_rsp_o.waitrequest);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without write");
endmodule
`default_nettype wire

/* verif/adc_timing_and_result_format_bench.sv */
// Self-checking bench for the converter timing and result format block
`timescale 1ns/1ps
`default_nettype none
module adc_timing_and_result_format_bench;
    // Design connections
    logic                   mclk_i  = 1'b0;
    logic                   rst_n_i = 1'b0;
    adc_ctl_pkg::avmm_req_t req     = '0;
    adc_ctl_pkg::avmm_rsp_t rsp;
    logic                   cmp_i   = 1'b0;
    logic [9:0]             dac_code;
    adc_ctl_pkg::cap_ctrl_t cap;
    logic                   irq;
    // Bench state
    int                     fails       = 0;
    int                     check_count = 0;
    int                     seed        = 43;
    logic [9:0]             vin         = 10'h000;
    logic [7:0]             q;
    int                     acq_tab[8]  = '{0, 2, 4, 6, 8, 12, 16, 20};
    int                     div_tab[8]  = '{2, 8, 32, adc_ctl_pkg::RC_DIV, 4, 16, 64, adc_ctl_pkg::RC_DIV};
    logic [2:0]             cs_tab[8]   = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h3, 3'h7, 3'h1, 3'h5};
    logic [4:0]             rst_tab[6]  = '{5'h00, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18};

    always #5 mclk_i = ~mclk_i;

    adc_timing_format i_adc_timing_format (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .avmm_req_i (req),
        .avmm_rsp_o (rsp),
        .cmp_i      (cmp_i),
        .dac_code_o (dac_code),
        .cap_ctrl_o (cap),
        .irq_o      (irq)
    );

    // Comparator stand-in, a cycle late like a real one
    always @(posedge mclk_i) cmp_i <= (vin >= dac_code);

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One bus cycle; an edge passes first so the strobe is never set twice in a step
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] rd);
        int n;
        @(posedge mclk_i);
        req.read       <= ~wr;
        req.write      <= wr;
        req.address    <= a;
        req.writedata  <= {24'h000000, d};
        req.byteenable <= 4'hf;
        n = 0;
        do begin
            @(posedge mclk_i);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 100);
        chk("bus answer", 1, n < 100);
        rd = rsp.readdata[7:0];
        req.read  <= 1'b0;
        req.write <= 1'b0;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One conversion with given delay, clock, justify and mask
    task automatic conv(input logic [2:0] acq, input logic [2:0] cs, input logic rj, input logic mk);
        int d;
        int e;
        int n;
        logic [7:0] hi;
        logic [7:0] lo;
        vin = 10'($random(seed));
        bus(1'b1, 5'h14, {7'h00, mk}, q);
        bus(1'b1, 5'h00, {rj, 1'b0, acq, cs}, q);
        // A fresh input needs settling; with no programmed delay the bench waits itself
        if (acq == 3'h0) begin
            repeat (20) @(posedge mclk_i);
        end
        bus(1'b1, 5'h04, 8'h01, q);
        e = acq_tab[acq] * div_tab[cs] + ((cs[1:0] == 2'b11) ? adc_ctl_pkg::INSTR_CYCLE_CLKS : 0);
        d = 0;
        do begin
            @(posedge mclk_i);
            d++;
        end while (cap.connect === 1'b1 && d < 5000);
        chk("acquisition span", 1, d >= e && d <= e + 2);
        bus(1'b0, 5'h04, 8'h00, q);
        chk("busy", 8'h01, q);
        // Neither a zero nor a second start may disturb the run
        bus(1'b1, 5'h04, 8'h00, q);
        bus(1'b1, 5'h04, 8'h01, q);
        bus(1'b0, 5'h04, 8'h00, q);
        chk("still busy", 8'h01, q);
        n = 0;
        while (cap.discharge !== 1'b1 && n < 2000) begin
            @(posedge mclk_i);
            n++;
        end
        chk("discharge", 1, cap.discharge);
        repeat (2) @(posedge mclk_i);
        chk("irq", mk, irq);
        bus(1'b0, 5'h04, 8'h00, q);
        chk("idle", 8'h00, q);
        bus(1'b0, 5'h08, 8'h00, hi);
        bus(1'b0, 5'h0c, 8'h00, lo);
        chk("result high", rj ? {6'h00, vin[9:8]} : vin[9:2], hi);
        chk("result low", rj ? vin[7:0] : {vin[1:0], 6'h00}, lo);
        bus(1'b0, 5'h10, 8'h00, q);
        chk("done status", 8'h01, q);
        bus(1'b1, 5'h10, 8'h01, q);
        bus(1'b0, 5'h10, 8'h00, q);
        chk("status cleared", 8'h00, q);
        chk("irq cleared", 0, irq);
    endtask

    // Watchdog, about three times the expected run of some ten thousand cycles
    initial begin
        repeat (30000) @(posedge mclk_i);
        fails++;
        $display("watchdog expired");
        close_out;
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        foreach (rst_tab[i]) begin
            bus(1'b0, rst_tab[i], 8'h00, q);
            chk("reset value", 8'h00, q);
        end
        chk("irq idle", 0, irq);
        bus(1'b1, 5'h00, 8'hff, q);
        bus(1'b0, 5'h00, 8'h00, q);
        chk("timing reg", 8'hbf, q);
        bus(1'b1, 5'h08, 8'h5a, q);
        bus(1'b0, 5'h08, 8'h00, q);
        chk("result high write", 8'h5a, q);
        bus(1'b1, 5'h18, 8'hff, q);
        bus(1'b0, 5'h18, 8'h00, q);
        chk("unmapped", 8'h00, q);
        for (int i = 0; i < 8; i++) begin
            conv(3'(i), cs_tab[i], i[0], ~i[1]);
        end
        close_out;
    end
endmodule

bind adc_timing_format adc_timing_format_assertions i_adc_timing_format_assertions (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .avmm_req_i (avmm_req_i),
    .avmm_rsp_o (avmm_rsp_o),
    .dac_code_o (dac_code_o),
    .cap_ctrl_o (cap_ctrl_o),
    .irq_o      (irq_o)
);
`default_nettype wire
